// ==== design/phy_mgmt_pkg.sv ====
package phy_mgmt_pkg;

  // ==========================================================
  // register indices on the management bus
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00, REG_BASIC_STATUS = 5'h01, REG_ID_HIGH = 5'h02;
  localparam logic [4:0] REG_ID_LOW = 5'h03, REG_ADVERTISE = 5'h04, REG_PARTNER = 5'h05, REG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_NP_TX = 5'h07, REG_PARTNER_NP = 5'h08, REG_GIG_CONTROL = 5'h09;
  localparam logic [4:0] REG_GIG_STATUS = 5'h0A, REG_IND_CONTROL = 5'h0D, REG_IND_DATA = 5'h0E;
  localparam logic [4:0] REG_EXT_STATUS = 5'h0F;

  // ==========================================================
  // field positions
  localparam int BC_LOOPBACK = 14, BC_SPEED_LSB = 13, BC_AN_EN = 12, BC_PDOWN = 11, BC_ISOLATE = 10;
  localparam int BC_RESTART = 9, BC_DUPLEX = 8, BC_COLTEST = 7, BC_SPEED_MSB = 6;
  localparam int BS_AN_DONE = 5, BS_RFAULT = 4, BS_LINK = 2, BS_JABBER = 1;
  localparam int PA_ACK = 14;
  localparam int EX_PDF = 4, EX_LP_NP = 3, EX_PAGE_RX = 1, EX_LP_AN = 0;
  localparam int NP_TOGGLE = 11;
  localparam int GC_TM_LO = 13, GC_MS_EN = 12, GC_MS_VAL = 11, GC_PORT = 10, GC_1000FD = 9, GC_1000HD = 8;
  localparam int GS_MSF = 15, GS_MSRES = 14, GS_LRX = 13, GS_RRX = 12, GS_LPFD = 11, GS_LPHD = 10;
  localparam int IC_MODE_LO = 14, IC_UPPER_LO = 5;

  // ==========================================================
  // reset values, fixed read values and write masks
  localparam logic [15:0] CTL_RST = 16'h1100, CTL_WMASK = 16'h7DC0;
  localparam logic [15:0] BS_FIXED = 16'h7949, EXT_STATUS_VAL = 16'h3000, EX_FIXED = 16'h0004;
  localparam logic [15:0] ADV_RST = 16'h01E1, ADV_WMASK = 16'hADFF;
  localparam logic [15:0] NP_RST = 16'h2001, NP_WMASK = 16'hB7FF;
  localparam logic [15:0] GC_RST = 16'h0200, GC_WMASK = 16'hFF00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] IDLE_MAX = 8'hFF;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {SPEED_10 = 2'b00, SPEED_100 = 2'b01, SPEED_1000 = 2'b10, SPEED_RSVD = 2'b11} speed_type;
  typedef enum logic [1:0] {IND_ADDR = 2'b00, IND_DATA = 2'b01, IND_INC_RW = 2'b10, IND_INC_WR = 2'b11} ind_mode_type;
  typedef enum logic [1:0] {PAUSE_NONE = 2'b00, PAUSE_SYM = 2'b01, PAUSE_ASYM = 2'b10, PAUSE_BOTH = 2'b11} pause_type;
  localparam logic [2:0] TM_NORMAL = 3'h0, TM_LAST = 3'h4;

  // ==========================================================
  // management frame fields
  localparam logic [1:0] OP_READ = 2'b10, OP_WRITE = 2'b01;
  localparam logic [4:0] HDR_LAST = 5'h0C, DATA_LAST = 5'h0F, WR_FIRST = 5'h02, FRAME_LAST = 5'h11;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic link_up, remote_fault, jabber, an_complete, parallel_fault, page_received;
    logic ms_fault, idle_rx_error, ms_master, local_rx_ok, remote_rx_ok;
    logic partner_1000fd, partner_1000hd, partner_np_able, partner_an_able, np_toggle;
    speed_type neg_speed;
    logic neg_full_duplex;
    logic [15:0] partner_ability, partner_next_page;
  } phy_status_type;

  typedef struct packed {
    logic isolate, restart_an, an_enable, loopback, power_down, collision_test;
    speed_type speed;
    logic full_duplex;
    logic [2:0] test_mode;
    logic ms_force, ms_master, port_multi, adv_1000fd, adv_1000hd;
    pause_type pause;
    logic [15:0] advertise, next_page;
  } phy_control_type;

  typedef struct packed {
    logic wr, rd;
    logic [4:0] dev;
    logic [15:0] addr, wdata;
  } ind_port_type;

endpackage

// ==== design/phy_mgmt_regs.sv ====
module phy_mgmt_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter logic [15:0] ID_OUI_HIGH = 16'h1234, // arbitrary value
  parameter logic [5:0] ID_OUI_LOW = 6'h15, // arbitrary value
  parameter logic [5:0] ID_MODEL = 6'h2A, // arbitrary value
  parameter logic [3:0] ID_REVISION = 4'h3, // arbitrary value
  parameter logic SPEED_MSB_DEFAULT = 1'b1,
  parameter logic GIG_HD_DEFAULT = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire phy_mgmt_pkg::phy_status_type i_status,
  input wire logic [15:0] i_ind_rdata,
  output phy_mgmt_pkg::phy_control_type o_ctrl,
  output phy_mgmt_pkg::ind_port_type o_ind
);

  // ==========================================================
  // pin synchronisers and edge finding
  logic [2:0] mdc_sync_r;
  logic [2:0] mdio_sync_r;
  logic mdc_lvl_r;
  logic mdio_lvl_r;
  logic mdc_rise;
  logic mdio_now;

  // three stages per pin; a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mdc_sync_r <= 3'h0;
      mdio_sync_r <= 3'h7;
      mdc_lvl_r <= 1'b0;
      mdio_lvl_r <= 1'b1;
    end
    else
    begin
      mdc_sync_r <= {mdc_sync_r[1:0], i_mdc};
      mdio_sync_r <= {mdio_sync_r[1:0], i_mdio};
      if (mdc_sync_r[1] == mdc_sync_r[2])
        mdc_lvl_r <= mdc_sync_r[2];
      if (mdio_sync_r[1] == mdio_sync_r[2])
        mdio_lvl_r <= mdio_sync_r[2];
    end
  end

  // rising clock edge and settled data level
  assign mdc_rise = (mdc_sync_r[1] == mdc_sync_r[2]) && mdc_sync_r[2] && !mdc_lvl_r;
  assign mdio_now = (mdio_sync_r[1] == mdio_sync_r[2]) ? mdio_sync_r[2] : mdio_lvl_r;

  // ==========================================================
  // frame engine
  typedef enum {ST_HUNT, ST_HDR, ST_RD_TA, ST_RD_DATA, ST_WR, ST_SKIP} frame_state_type;
  frame_state_type state_r;
  logic [4:0] cnt_r;
  logic [11:0] hdr_r;
  logic [12:0] hdr_full;
  logic [15:0] shift_r;
  logic [15:0] rdata_nxt;
  logic rd_stb_r;
  logic wr_stb_r;
  logic [4:0] idx_r;
  logic [15:0] wdata_r;
  logic mdio_o_r;
  logic mdio_oe_r;

  assign hdr_full = {hdr_r, mdio_now};

  // strobe tests shared by every register with a write or read side effect
  function automatic logic rd_hit(input logic [4:0] idx);
    rd_hit = rd_stb_r && (idx_r == idx);
  endfunction

  function automatic logic wr_hit(input logic [4:0] idx);
    wr_hit = wr_stb_r && (idx_r == idx);
  endfunction

  // start bit, header, turnaround and data, sampled on mdc rise
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= ST_HUNT;
      cnt_r <= 5'h00;
      hdr_r <= 12'h000;
      idx_r <= 5'h00;
      wdata_r <= phy_mgmt_pkg::ZERO16;
      rd_stb_r <= 1'b0;
      wr_stb_r <= 1'b0;
      mdio_o_r <= 1'b0;
      mdio_oe_r <= 1'b0;
    end
    else
    begin
      rd_stb_r <= 1'b0;
      wr_stb_r <= 1'b0;
      if (mdc_rise)
      begin
        case (state_r)
          ST_HUNT:
          begin
            cnt_r <= 5'h00;
            if (!mdio_now)
              state_r <= ST_HDR;
          end
          ST_HDR:
          begin
            hdr_r <= hdr_full[11:0];
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == phy_mgmt_pkg::HDR_LAST)
            begin
              cnt_r <= 5'h00;
              idx_r <= hdr_full[4:0];
              state_r <= ST_SKIP;
              if (hdr_full[12] && hdr_full[9:5] == PHY_ADDR)
              begin
                if (hdr_full[11:10] == phy_mgmt_pkg::OP_READ)
                begin
                  rd_stb_r <= 1'b1;
                  state_r <= ST_RD_TA;
                end
                else if (hdr_full[11:10] == phy_mgmt_pkg::OP_WRITE)
                  state_r <= ST_WR;
              end
            end
          end
          ST_RD_TA:
          begin
            mdio_oe_r <= 1'b1;
            mdio_o_r <= 1'b0;
            state_r <= ST_RD_DATA;
          end
          ST_RD_DATA:
          begin
            cnt_r <= cnt_r + 5'h01;
            mdio_o_r <= shift_r[15];
            if (cnt_r > phy_mgmt_pkg::DATA_LAST)
            begin
              mdio_oe_r <= 1'b0;
              state_r <= ST_HUNT;
            end
          end
          ST_WR:
          begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r >= phy_mgmt_pkg::WR_FIRST)
              wdata_r <= {wdata_r[14:0], mdio_now};
            if (cnt_r == phy_mgmt_pkg::FRAME_LAST)
            begin
              wr_stb_r <= 1'b1;
              state_r <= ST_HUNT;
            end
          end
          ST_SKIP:
          begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == phy_mgmt_pkg::FRAME_LAST)
              state_r <= ST_HUNT;
          end
          default:
            state_r <= ST_HUNT;
        endcase
      end
    end
  end

  // read shifter, loaded once per read frame
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      shift_r <= phy_mgmt_pkg::ZERO16;
    else if (rd_stb_r)
      shift_r <= rdata_nxt;
    else if (mdc_rise && state_r == ST_RD_DATA)
      shift_r <= {shift_r[14:0], 1'b0};
  end

  // ==========================================================
  // writable registers
  logic [15:0] ctl_r;
  logic [15:0] adv_r;
  logic [15:0] np_r;
  logic [15:0] gc_r;
  logic [10:0] ic_upper_r;
  logic restart_r;
  logic ind_inc_r;
  phy_mgmt_pkg::ind_port_type ind_r;
  phy_mgmt_pkg::ind_mode_type ind_mode;

  assign ind_mode = phy_mgmt_pkg::ind_mode_type'(ic_upper_r[10:9]);

  // basic control; restart is never stored so it reads zero
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctl_r <= phy_mgmt_pkg::CTL_RST | {9'h000, SPEED_MSB_DEFAULT, 6'h00};
      restart_r <= 1'b0;
    end
    else
    begin
      restart_r <= wr_hit(phy_mgmt_pkg::REG_BASIC_CONTROL) && wdata_r[phy_mgmt_pkg::BC_RESTART];
      if (wr_hit(phy_mgmt_pkg::REG_BASIC_CONTROL))
        ctl_r <= wdata_r & phy_mgmt_pkg::CTL_WMASK;
    end
  end

  // advertisement, next page and gigabit control
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      adv_r <= phy_mgmt_pkg::ADV_RST;
      np_r <= phy_mgmt_pkg::NP_RST;
      gc_r <= phy_mgmt_pkg::GC_RST | {7'h00, GIG_HD_DEFAULT, 8'h00};
    end
    else
    begin
      if (wr_hit(phy_mgmt_pkg::REG_ADVERTISE))
        adv_r <= wdata_r & phy_mgmt_pkg::ADV_WMASK;
      if (wr_hit(phy_mgmt_pkg::REG_NP_TX))
        np_r <= wdata_r & phy_mgmt_pkg::NP_WMASK;
      if (wr_hit(phy_mgmt_pkg::REG_GIG_CONTROL))
        gc_r <= wdata_r & phy_mgmt_pkg::GC_WMASK;
    end
  end

  // indirect portal: address in mode zero, data moves otherwise
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ic_upper_r <= 11'h000;
      ind_r <= '0;
      ind_inc_r <= 1'b0;
    end
    else
    begin
      ind_r.wr <= 1'b0;
      ind_r.rd <= 1'b0;
      ind_inc_r <= 1'b0;
      if (wr_hit(phy_mgmt_pkg::REG_IND_CONTROL))
      begin
        ic_upper_r <= wdata_r[15:5];
        ind_r.dev <= wdata_r[4:0];
      end
      if (wr_hit(phy_mgmt_pkg::REG_IND_DATA))
      begin
        if (ind_mode == phy_mgmt_pkg::IND_ADDR)
          ind_r.addr <= wdata_r;
        else
        begin
          ind_r.wr <= 1'b1;
          ind_r.wdata <= wdata_r;
          ind_inc_r <= (ind_mode != phy_mgmt_pkg::IND_DATA);
        end
      end
      if (rd_hit(phy_mgmt_pkg::REG_IND_DATA) && ind_mode != phy_mgmt_pkg::IND_ADDR)
      begin
        ind_r.rd <= 1'b1;
        ind_inc_r <= (ind_mode == phy_mgmt_pkg::IND_INC_RW);
      end
      // increment after the access pulse so the pulse shows the old address
      if (ind_inc_r)
        ind_r.addr <= ind_r.addr + 16'h0001;
    end
  end

  // ==========================================================
  // latched status and idle error counter
  logic rfault_r;
  logic jab_r;
  logic link_ll_r;
  logic pdf_r;
  logic page_rx_r;
  logic msf_r;
  logic [7:0] idle_cnt_r;

  // set wins over the clear that a read of the register makes
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rfault_r <= 1'b0;
      jab_r <= 1'b0;
      link_ll_r <= 1'b0;
      pdf_r <= 1'b0;
      page_rx_r <= 1'b0;
      msf_r <= 1'b0;
    end
    else
    begin
      rfault_r <= (rfault_r && !rd_hit(phy_mgmt_pkg::REG_BASIC_STATUS)) || i_status.remote_fault;
      jab_r <= (jab_r && !rd_hit(phy_mgmt_pkg::REG_BASIC_STATUS)) || i_status.jabber;
      if (!i_status.link_up)
        link_ll_r <= 1'b0;
      else if (rd_hit(phy_mgmt_pkg::REG_BASIC_STATUS))
        link_ll_r <= 1'b1;
      pdf_r <= (pdf_r && !rd_hit(phy_mgmt_pkg::REG_EXPANSION)) || i_status.parallel_fault;
      page_rx_r <= (page_rx_r && !rd_hit(phy_mgmt_pkg::REG_EXPANSION)) || i_status.page_received;
      msf_r <= (msf_r && !rd_hit(phy_mgmt_pkg::REG_GIG_STATUS)) || i_status.ms_fault;
    end
  end

  // saturating count; an error in the clearing cycle starts at one
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      idle_cnt_r <= 8'h00;
    else if (rd_hit(phy_mgmt_pkg::REG_GIG_STATUS))
      idle_cnt_r <= {7'h00, i_status.idle_rx_error};
    else if (i_status.idle_rx_error && idle_cnt_r != phy_mgmt_pkg::IDLE_MAX)
      idle_cnt_r <= idle_cnt_r + 8'h01;
  end

  // ==========================================================
  // read mux
  always_comb
  begin
    rdata_nxt = phy_mgmt_pkg::ZERO16;
    case (idx_r)
      phy_mgmt_pkg::REG_BASIC_CONTROL: rdata_nxt = ctl_r;
      phy_mgmt_pkg::REG_BASIC_STATUS:
      begin
        rdata_nxt = phy_mgmt_pkg::BS_FIXED;
        rdata_nxt[phy_mgmt_pkg::BS_AN_DONE] = i_status.an_complete;
        rdata_nxt[phy_mgmt_pkg::BS_RFAULT] = rfault_r;
        rdata_nxt[phy_mgmt_pkg::BS_LINK] = link_ll_r;
        rdata_nxt[phy_mgmt_pkg::BS_JABBER] = jab_r;
      end
      phy_mgmt_pkg::REG_ID_HIGH: rdata_nxt = ID_OUI_HIGH;
      phy_mgmt_pkg::REG_ID_LOW: rdata_nxt = {ID_OUI_LOW, ID_MODEL, ID_REVISION};
      phy_mgmt_pkg::REG_ADVERTISE: rdata_nxt = adv_r;
      phy_mgmt_pkg::REG_PARTNER: rdata_nxt = i_status.partner_ability;
      phy_mgmt_pkg::REG_EXPANSION:
      begin
        rdata_nxt = phy_mgmt_pkg::EX_FIXED;
        rdata_nxt[phy_mgmt_pkg::EX_PDF] = pdf_r;
        rdata_nxt[phy_mgmt_pkg::EX_LP_NP] = i_status.partner_np_able;
        rdata_nxt[phy_mgmt_pkg::EX_PAGE_RX] = page_rx_r;
        rdata_nxt[phy_mgmt_pkg::EX_LP_AN] = i_status.partner_an_able;
      end
      phy_mgmt_pkg::REG_NP_TX:
      begin
        rdata_nxt = np_r;
        rdata_nxt[phy_mgmt_pkg::NP_TOGGLE] = i_status.np_toggle;
      end
      phy_mgmt_pkg::REG_PARTNER_NP: rdata_nxt = i_status.partner_next_page;
      phy_mgmt_pkg::REG_GIG_CONTROL: rdata_nxt = gc_r;
      phy_mgmt_pkg::REG_GIG_STATUS:
      begin
        rdata_nxt[7:0] = idle_cnt_r;
        rdata_nxt[phy_mgmt_pkg::GS_MSF] = msf_r;
        rdata_nxt[phy_mgmt_pkg::GS_MSRES] = i_status.ms_master;
        rdata_nxt[phy_mgmt_pkg::GS_LRX] = i_status.local_rx_ok;
        rdata_nxt[phy_mgmt_pkg::GS_RRX] = i_status.remote_rx_ok;
        rdata_nxt[phy_mgmt_pkg::GS_LPFD] = i_status.partner_1000fd;
        rdata_nxt[phy_mgmt_pkg::GS_LPHD] = i_status.partner_1000hd;
      end
      phy_mgmt_pkg::REG_IND_CONTROL: rdata_nxt = {ic_upper_r, ind_r.dev};
      phy_mgmt_pkg::REG_IND_DATA: rdata_nxt = (ind_mode == phy_mgmt_pkg::IND_ADDR) ? ind_r.addr : i_ind_rdata;
      phy_mgmt_pkg::REG_EXT_STATUS: rdata_nxt = phy_mgmt_pkg::EXT_STATUS_VAL;
      default: rdata_nxt = phy_mgmt_pkg::ZERO16;
    endcase
  end

  // ==========================================================
  // control outputs
  phy_mgmt_pkg::speed_type manual_speed;
  logic [2:0] tm_code;

  assign manual_speed = phy_mgmt_pkg::speed_type'({ctl_r[phy_mgmt_pkg::BC_SPEED_MSB], ctl_r[phy_mgmt_pkg::BC_SPEED_LSB]});
  assign tm_code = gc_r[phy_mgmt_pkg::GC_TM_LO +: 3];

  // effective settings driven to the datapath
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_ctrl <= '0;
    else
    begin
      o_ctrl.isolate <= ctl_r[phy_mgmt_pkg::BC_ISOLATE];
      o_ctrl.restart_an <= restart_r;
      o_ctrl.an_enable <= ctl_r[phy_mgmt_pkg::BC_AN_EN];
      o_ctrl.loopback <= ctl_r[phy_mgmt_pkg::BC_LOOPBACK];
      o_ctrl.power_down <= ctl_r[phy_mgmt_pkg::BC_PDOWN];
      o_ctrl.collision_test <= ctl_r[phy_mgmt_pkg::BC_COLTEST];
      o_ctrl.speed <= ctl_r[phy_mgmt_pkg::BC_AN_EN] ? i_status.neg_speed : manual_speed;
      o_ctrl.full_duplex <= ctl_r[phy_mgmt_pkg::BC_AN_EN] ? i_status.neg_full_duplex : ctl_r[phy_mgmt_pkg::BC_DUPLEX];
      // test waveforms only after negotiation is off and gigabit forced
      o_ctrl.test_mode <= (!ctl_r[phy_mgmt_pkg::BC_AN_EN] && manual_speed == phy_mgmt_pkg::SPEED_1000 &&
                           tm_code <= phy_mgmt_pkg::TM_LAST) ? tm_code : phy_mgmt_pkg::TM_NORMAL;
      o_ctrl.ms_force <= gc_r[phy_mgmt_pkg::GC_MS_EN];
      o_ctrl.ms_master <= gc_r[phy_mgmt_pkg::GC_MS_EN] && gc_r[phy_mgmt_pkg::GC_MS_VAL];
      o_ctrl.port_multi <= !gc_r[phy_mgmt_pkg::GC_MS_EN] && gc_r[phy_mgmt_pkg::GC_PORT];
      o_ctrl.adv_1000fd <= gc_r[phy_mgmt_pkg::GC_1000FD];
      o_ctrl.adv_1000hd <= gc_r[phy_mgmt_pkg::GC_1000HD];
      o_ctrl.pause <= phy_mgmt_pkg::pause_type'(adv_r[11:10]);
      o_ctrl.advertise <= adv_r;
      o_ctrl.next_page <= np_r;
    end
  end

  assign o_mdio = mdio_o_r;
  assign o_mdio_oe = mdio_oe_r;
  assign o_ind = ind_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  chk_isolate_write: assert property (wr_hit(phy_mgmt_pkg::REG_BASIC_CONTROL) |-> ##2
    o_ctrl.isolate == $past(wdata_r[phy_mgmt_pkg::BC_ISOLATE], 2)) else $error("isolate not applied");
  chk_restart_pulse: assert property (wr_hit(phy_mgmt_pkg::REG_BASIC_CONTROL) && wdata_r[phy_mgmt_pkg::BC_RESTART]
    |-> ##2 o_ctrl.restart_an ##1 !o_ctrl.restart_an && !ctl_r[phy_mgmt_pkg::BC_RESTART]) else $error("restart pulse");
  chk_speed_auto: assert property (ctl_r[phy_mgmt_pkg::BC_AN_EN] |=> o_ctrl.speed == $past(i_status.neg_speed))
    else $error("negotiated speed not used");
  chk_rfault_hold: assert property (rfault_r && !rd_hit(phy_mgmt_pkg::REG_BASIC_STATUS) |=> rfault_r)
    else $error("remote fault dropped");
  chk_link_low: assert property (!i_status.link_up |=> !link_ll_r [*1] ##0 !rdata_nxt[phy_mgmt_pkg::BS_LINK]
    || idx_r != phy_mgmt_pkg::REG_BASIC_STATUS) else $error("link low not latched");
  chk_jabber_set: assert property (i_status.jabber |=> jab_r) else $error("jabber not latched");
  chk_page_clear: assert property (rd_hit(phy_mgmt_pkg::REG_EXPANSION) && !i_status.page_received |=> !page_rx_r)
    else $error("page flag not cleared");
  chk_msf_clear: assert property (rd_hit(phy_mgmt_pkg::REG_GIG_STATUS) && !i_status.ms_fault |=> !msf_r)
    else $error("config fault not cleared");
  chk_idle_count: assert property (i_status.idle_rx_error && !rd_hit(phy_mgmt_pkg::REG_GIG_STATUS) &&
    idle_cnt_r != phy_mgmt_pkg::IDLE_MAX |=> idle_cnt_r == $past(idle_cnt_r) + 8'h01) else $error("idle count");
  chk_ind_incr: assert property (wr_hit(phy_mgmt_pkg::REG_IND_DATA) && ind_mode == phy_mgmt_pkg::IND_INC_RW
    |=> o_ind.wr ##1 o_ind.addr == $past(o_ind.addr) + 16'h0001) else $error("post increment");
  chk_test_gate: assert property (o_ctrl.test_mode != phy_mgmt_pkg::TM_NORMAL |->
    $past(!ctl_r[phy_mgmt_pkg::BC_AN_EN] && manual_speed == phy_mgmt_pkg::SPEED_1000)) else $error("test mode gate");

  cov_read_frame: cover property (rd_stb_r ##[1:300] (mdc_rise && state_r == ST_RD_DATA));
  cov_write_frame: cover property (wr_hit(phy_mgmt_pkg::REG_BASIC_CONTROL));
  cov_ind_write: cover property (o_ind.wr);
  cov_restart: cover property (o_ctrl.restart_an);

endmodule

// ==== dv/mdio_station.sv ====
module mdio_station (
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire logic i_mdio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] shift_r;
  // data moves while the clock is low, sampled at the rise
  task automatic send_bit(input logic b, input logic drv);
    o_mdio = b;
    o_mdio_oe = drv;
    #32 o_mdc = 1'b1;
    shift_r = {shift_r[30:0], i_mdio};
    #32 o_mdc = 1'b0;
  endtask
  // ==========================================================
  // frame: two preamble ones, released during read turnaround
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] w;
    w = {2'b01, op, 5'h01, ra, 2'b10, wd};
    send_bit(1'b1, 1'b1);
    send_bit(1'b1, 1'b1);
    for (int i = 31; i >= 0; i--)
      send_bit(w[i], (op == 2'b01) || (i > 17));
    send_bit(1'b1, 1'b0); // idle, clock then stands low
    rd = shift_r[16:1];
  endtask
  // idle: released, clock low
  initial
  begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
    shift_r = 32'h0;
  end
endmodule

// ==== dv/phy_standard_mgmt_registers_bench.sv ====
module phy_standard_mgmt_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic mdc, m_o, m_oe, d_o, d_oe, seen_rs;
  logic [15:0] wr_addr, wr_data, rd;
  int bad_count = 0;
  int n_tests = 0;
  int n_rd = 0;
  phy_mgmt_pkg::phy_status_type st = '0;
  phy_mgmt_pkg::phy_control_type ctl;
  phy_mgmt_pkg::ind_port_type ind;
  wire logic mdio = d_oe ? d_o : (m_oe ? m_o : 1'b1); // pull-up when released
  wire logic [15:0] ird = ind.addr ^ 16'h5A5A;
  phy_mgmt_regs dut_u (.i_clk_sys(clk), .i_rst_b(rst_b), .i_mdc(mdc), .i_mdio(mdio), .o_mdio(d_o),
    .o_mdio_oe(d_oe), .i_status(st), .i_ind_rdata(ird), .o_ctrl(ctl), .o_ind(ind));
  mdio_station mgr_u (.o_mdc(mdc), .o_mdio(m_o), .o_mdio_oe(m_oe), .i_mdio(mdio));
  // ==========================================================
  // clock and pulse catchers
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (!rst_b)
      seen_rs <= 1'b0;
    else if (ctl.restart_an === 1'b1)
      seen_rs <= 1'b1;
    if (ind.wr === 1'b1)
      {wr_addr, wr_data} <= {ind.addr, ind.wdata};
    if (ind.rd === 1'b1)
      n_rd <= n_rd + 1;
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    @(negedge clk);
    mgr_u.frame(2'b01, ra, d, rd);
    @(negedge clk);
  endtask
  task automatic rchk(input logic [4:0] ra, input logic [15:0] e);
    @(negedge clk);
    mgr_u.frame(2'b10, ra, 16'h0000, rd);
    @(negedge clk);
    chk(rd, e);
  endtask
  task automatic ev(input logic [7:0] v);
    {st.link_up, st.remote_fault, st.jabber, st.an_complete, st.parallel_fault, st.page_received, st.ms_fault,
      st.idle_rx_error} = v;
    @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_defaults();
    rchk(5'h00, 16'h1140);
    rchk(5'h01, 16'h7949);
    chk(ctl.isolate, 1'b0);
    wr(5'h02, 16'hFFFF);
    rchk(5'h02, 16'h1234);
    rchk(5'h03, 16'h56A3);
    rchk(5'h07, 16'h2001);
    wr(5'h07, 16'h07FF);
    rchk(5'h07, 16'h07FF);
    chk(ctl.next_page, 16'h07FF);
    rchk(5'h0B, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h04, 16'h01E1 | (k[15:0] << 10));
      chk(ctl.pause, k[15:0]);
    end
  endtask
  task automatic t_ctrl();
    logic [15:0] cw [4] = '{16'h0100, 16'h2100, 16'h0140, 16'h2140};
    wr(5'h00, 16'h0540);
    chk(ctl.isolate, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h00, cw[k]);
      chk(ctl.speed, k[15:0]);
    end
    wr(5'h00, 16'h0000);
    chk(ctl.full_duplex, 1'b0);
    st.neg_speed = phy_mgmt_pkg::SPEED_100;
    wr(5'h00, 16'h1240);
    chk(ctl.speed, phy_mgmt_pkg::SPEED_100);
    chk(seen_rs, 1'b1);
    rchk(5'h00, 16'h1040);
  endtask
  task automatic t_test();
    wr(5'h00, 16'h0140);
    for (int k = 0; k < 6; k++)
    begin
      wr(5'h09, {k[2:0], 13'h0200});
      chk(ctl.test_mode, (k < 5) ? k[2:0] : 3'h0);
    end
    rchk(5'h09, 16'hA200);
    wr(5'h09, 16'h0C00);
    chk(ctl.ms_master, 1'b0);
    chk(ctl.port_multi, 1'b1);
    wr(5'h09, 16'h1C00);
    chk(ctl.ms_master, 1'b1);
    chk(ctl.port_multi, 1'b0);
  endtask
  task automatic t_latch();
    st.partner_ability = 16'h4000;
    ev(8'b0111_1111);
    for (int k = 0; k < 5; k++)
      ev({7'b1001_000, k[0]});
    rchk(5'h01, 16'h797B);
    rchk(5'h01, 16'h796D);
    rchk(5'h06, 16'h0016);
    rchk(5'h06, 16'h0004);
    rchk(5'h0A, 16'h8003);
    rchk(5'h0A, 16'h0000);
    rchk(5'h05, 16'h4000);
  endtask
  task automatic t_ind();
    wr(5'h0D, 16'h0002);
    wr(5'h0E, 16'h0010);
    chk(ind.addr, 16'h0010);
    chk(ind.dev, 5'h02);
    wr(5'h0D, 16'h8002);
    wr(5'h0E, 16'hABCD);
    chk(wr_data, 16'hABCD);
    chk(wr_addr, 16'h0010);
    chk(ind.addr, 16'h0011);
    rchk(5'h0E, 16'h5A4B);
    chk(ind.addr, 16'h0012);
    wr(5'h0D, 16'hC002);
    rchk(5'h0E, 16'h5A48);
    chk(ind.addr, 16'h0012);
    wr(5'h0E, 16'h1111);
    chk(ind.addr, 16'h0013);
    rchk(5'h0D, 16'hC002);
    wr(5'h0D, 16'h4002);
    wr(5'h0E, 16'h2222);
    chk(wr_data, 16'h2222);
    chk(ind.addr, 16'h0013);
    rchk(5'h0E, 16'h5A49);
    chk(ind.addr, 16'h0013);
    chk(n_rd, 16'h0003);
  endtask
  task automatic finish_test();
    $display("tests=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    t_defaults();
    t_ctrl();
    t_test();
    t_latch();
    t_ind();
    finish_test();
  end
  initial
  begin
    #400us;
    bad_count++;
    finish_test();
  end
endmodule
